// ==== core/fgp_gpio_port.sv ====
// four-pin gpio port with register access, power-on capture and output-enable role
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module fgp_gpio_port
  import fgp_pkg::*;
#(
  parameter int PINS = fgp_pkg::PIN_COUNT
) (
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic                            reg_write,
  input  wire logic                            reg_read,
  input  wire logic [fgp_pkg::ADDR_WIDTH-1:0]  reg_addr,
  input  wire logic [fgp_pkg::DATA_WIDTH-1:0]  reg_wdata,
  output logic      [fgp_pkg::DATA_WIDTH-1:0]  reg_rdata,
  input  wire logic [PINS-1:0]                 gpio_in,
  output logic      [PINS-1:0]                 gpio_out,
  output logic      [PINS-1:0]                 gpio_oe,
  output logic      [fgp_pkg::SLEW_WIDTH-1:0]  pad_slew,
  input  wire logic                            par_port_enable,
  output logic                                 par_port_drive
);
  import fgp_pkg::*;

  logic [PINS-1:0]       pin_meta_q;
  logic [PINS-1:0]       pin_sync_q;
  logic [PINS-1:0]       power_on_q;
  logic [PINS-1:0]       dir_q;
  logic [PINS-1:0]       out_level_q;
  logic                  oe_role_q;
  logic [SLEW_WIDTH-1:0] slew_q;
  logic [PINS-1:0]       set_bits;
  logic [PINS-1:0]       clr_bits;
  logic                  write_oe_cfg;
  logic                  write_slew;
  logic                  write_dir;
  logic                  write_set;
  logic                  write_clear;
  logic [PINS-1:0]       drive_en;
  logic [PINS-1:0]       out_level_d;
  logic [DATA_WIDTH-1:0] rdata_d;
  logic                  oe_bar_raw;

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= gpio_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power-on capture: two edges let the synchroniser fill, the third takes the pins
  // one-hot codes, so an upset shows up as an illegal code
  typedef enum logic [3:0] {
    CAP_FILL_FIRST  = 4'b0001,
    CAP_FILL_SECOND = 4'b0010,
    CAP_TAKE        = 4'b0100,
    CAP_DONE        = 4'b1000
  } fgp_capture_type;

  fgp_capture_type capture_q;
  fgp_capture_type capture_d;

  always_comb begin
    capture_d = capture_q;
    unique case (capture_q)
      CAP_FILL_FIRST:  capture_d = CAP_FILL_SECOND;
      CAP_FILL_SECOND: capture_d = CAP_TAKE;
      CAP_TAKE:        capture_d = CAP_DONE;
      CAP_DONE:        capture_d = CAP_DONE;
      // an illegal code ends the sequence rather than taking a second capture
      default:         capture_d = CAP_DONE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capture_q <= CAP_FILL_FIRST;
    end else begin
      capture_q <= capture_d;
    end
  end

  // the captured word stays put until the next reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_on_q <= '0;
    end else if (capture_q == CAP_TAKE) begin
      power_on_q <= pin_sync_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register write decode, exact address match only
  // writes to read-only or unknown addresses match nothing and change nothing
  assign write_oe_cfg = reg_write && (reg_addr == OE_PIN_CFG_ADDR);
  assign write_slew   = reg_write && (reg_addr == SLEW_CTRL_ADDR);
  assign write_dir    = reg_write && (reg_addr == DIRECTION_ADDR);
  assign write_set    = reg_write && (reg_addr == SET_CMD_ADDR);
  assign write_clear  = reg_write && (reg_addr == CLEAR_CMD_ADDR);

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oe_role_q <= OE_ROLE_RESET;
    end else if (write_oe_cfg) begin
      oe_role_q <= reg_wdata[OE_ROLE_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slew_q <= SLEW_RESET;
    end else if (write_slew) begin
      slew_q <= reg_wdata[SLEW_LSB +: SLEW_WIDTH];
    end
  end

  // a pin turned to input keeps its output level for when it turns back
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= DIRECTION_RESET;
    end else if (write_dir) begin
      dir_q <= reg_wdata[PIN_FIELD_LSB +: PINS];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // set and clear commands; a command to an input pin is dropped, not held
  // both commands are pulses, nothing is remembered between writes
  // bit 9 is pin 0
  assign set_bits = write_set ? reg_wdata[PIN_FIELD_LSB +: PINS] : '0;
  assign clr_bits = write_clear ? reg_wdata[PIN_FIELD_LSB +: PINS] : '0;

  for (genvar p = 0; p < PINS; p++) begin : g_pin
    // output when direction bit is 0
    assign drive_en[p] = (dir_q[p] == DIR_OUTPUT);
    // clear drives low, set wins if both land together
    assign out_level_d[p] = !drive_en[p] ? out_level_q[p] :
                            set_bits[p]  ? 1'b1 :
                            clr_bits[p]  ? 1'b0 :
                                           out_level_q[p];
  end

  // outputs start low, though no pad drives until a direction write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_level_q <= OUT_LEVEL_RESET;
    end else begin
      out_level_q <= out_level_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pad drive; pin 3 never driven while it serves as output enable
  always_comb begin
    gpio_oe = drive_en;
    if (oe_role_q) begin
      gpio_oe[PINS-1] = 1'b0;
    end
  end

  assign gpio_out = out_level_q;
  assign pad_slew = slew_q;

  //////////////////////////////////////////////////////////////////////////////
  // parallel-port output enable, active low on the top pin
  // a synchroniser here would put a clock into the enable path
  assign oe_bar_raw = gpio_in[PINS-1];

  // raw pin, no clock in the path
  assign par_port_drive = par_port_enable & (!oe_role_q | !oe_bar_raw);

  //////////////////////////////////////////////////////////////////////////////
  // register read; unmapped and write-only addresses read as zero
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      OE_PIN_CFG_ADDR: rdata_d[OE_ROLE_BIT] = oe_role_q;
      SLEW_CTRL_ADDR:  rdata_d[SLEW_LSB +: SLEW_WIDTH] = slew_q;
      POWER_ON_ADDR:   rdata_d[POWER_ON_LSB +: PINS] = power_on_q;
      LEVEL_READ_ADDR: rdata_d[PIN_FIELD_LSB +: PINS] = pin_sync_q;
      DIRECTION_ADDR:  rdata_d[PIN_FIELD_LSB +: PINS] = dir_q;
      default: ;
    endcase
  end

  // a read and a write in one cycle return the value from before the write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule

// ==== core/fgp_pkg.sv ====
// constants for the four-pin gpio port: offsets, fields and reset values
package fgp_pkg;
  localparam int          PIN_COUNT        = 4;
  localparam int          ADDR_WIDTH       = 16;
  localparam int          DATA_WIDTH       = 16;
  // register offsets
  localparam logic [15:0] OE_PIN_CFG_ADDR  = 16'h001A;
  localparam logic [15:0] SLEW_CTRL_ADDR   = 16'h001E;
  localparam logic [15:0] POWER_ON_ADDR    = 16'h0024;
  localparam logic [15:0] LEVEL_READ_ADDR  = 16'h1070;
  localparam logic [15:0] SET_CMD_ADDR     = 16'h1074;
  localparam logic [15:0] CLEAR_CMD_ADDR   = 16'h1076;
  localparam logic [15:0] DIRECTION_ADDR   = 16'h1078;
  // field positions
  localparam int          OE_ROLE_BIT      = 8;
  localparam int          SLEW_LSB         = 4;
  localparam int          SLEW_WIDTH       = 3;
  localparam int          POWER_ON_LSB     = 0;
  localparam int          PIN_FIELD_LSB    = 9;
  // reset values
  localparam logic        OE_ROLE_RESET    = 1'b0;
  localparam logic [2:0]  SLEW_RESET       = 3'h0;
  localparam logic [3:0]  DIRECTION_RESET  = 4'hF;
  localparam logic [3:0]  OUT_LEVEL_RESET  = 4'h0;
  // pin directions in the direction field
  localparam logic        DIR_OUTPUT       = 1'b0;
  localparam logic        DIR_INPUT        = 1'b1;
endpackage

// ==== bench/fgp_props.sv ====
// assertion checker for the gpio port top ports
`timescale 1ns/1ps
module fgp_props
  import fgp_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic        par_port_enable,
  input wire logic        par_port_drive,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [3:0]  gpio_in,
  input wire logic [3:0]  gpio_out,
  input wire logic [3:0]  gpio_oe,
  input wire logic [2:0]  pad_slew
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire w = reg_write;
  wire r = reg_read;
  dir_reset_a: assert property ($rose(rst_n) |-> gpio_oe == 4'h0)
    else $error("pins not inputs after reset");
  dir_write_a: assert property (w && reg_addr == DIRECTION_ADDR
    |=> gpio_oe[2:0] == ~$past(reg_wdata[11:9])) else $error("direction not applied");
  set_pin_a: assert property (w && reg_addr == SET_CMD_ADDR && reg_wdata[9] && gpio_oe[0]
    |=> gpio_out[0]) else $error("set not applied");
  clear_pin_a: assert property (w && reg_addr == CLEAR_CMD_ADDR && reg_wdata[9] && gpio_oe[0]
    |=> !gpio_out[0]) else $error("clear not applied");
  slew_write_a: assert property (w && reg_addr == SLEW_CTRL_ADDR
    |=> pad_slew == $past(reg_wdata[6:4])) else $error("slew not applied");
  level_read_a: assert property (r && reg_addr == LEVEL_READ_ADDR && $stable(gpio_in)
    && gpio_in == $past(gpio_in, 2) |=> reg_rdata[12:9] == $past(gpio_in))
    else $error("level readback wrong");
  cmd_read_a: assert property (r && reg_addr == SET_CMD_ADDR |=> reg_rdata == 16'h0000)
    else $error("write-only read not zero");
  port_idle_a: assert property (!par_port_enable |-> !par_port_drive)
    else $error("parallel port driven while off");
endmodule

// ==== bench/fgp_pin_model.sv ====
// outside circuit on the four gpio pads
`timescale 1ns/1ps
module fgp_pin_model (
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe,
  input  wire logic [3:0] ext_level,
  output logic      [3:0] gpio_in
);
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule

// ==== bench/fgp_gpio_port_tb.sv ====
// self-checking testbench for the four-pin gpio port
`timescale 1ns/1ps
module fgp_gpio_port_tb;
  import fgp_pkg::*;
  logic        clock = 0, rst_n = 0, reg_write = 0, reg_read = 0, par_port_enable = 0;
  logic        par_port_drive;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic [3:0]  gpio_in, gpio_out, gpio_oe, ext = 4'h5;
  logic [2:0]  pad_slew;
  int          miscompares = 0, checks = 0;
  always #12.5 clock = ~clock;
  fgp_pin_model PADS (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext), .gpio_in(gpio_in));
  fgp_gpio_port DUT (.*);
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
    @(posedge clock);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    chk("oe", gpio_oe, 4'h0);
    acc(0, DIRECTION_ADDR, 16'h0000);
    chk("dir", reg_rdata, 16'h1E00);
    acc(0, SLEW_CTRL_ADDR, 16'h0000);
    chk("slew", reg_rdata, 16'h0000);
    acc(0, POWER_ON_ADDR, 16'h0000);
    chk("pwron", reg_rdata, 16'h0005);
  endtask
  task automatic t_pins;
    acc(1, DIRECTION_ADDR, 16'h0000);
    chk("oe", gpio_oe, 4'hF);
    acc(1, SET_CMD_ADDR, 16'h1E00);
    chk("out", gpio_out, 4'hF);
    acc(1, CLEAR_CMD_ADDR, 16'h0600);
    chk("out", gpio_out, 4'hC);
    repeat (2) @(posedge clock);
    acc(0, LEVEL_READ_ADDR, 16'h0000);
    chk("level", reg_rdata, 16'h1800);
    acc(0, SET_CMD_ADDR, 16'h0000);
    chk("wo", reg_rdata, 16'h0000);
    acc(1, DIRECTION_ADDR, 16'h1E00);
    acc(1, SET_CMD_ADDR, 16'h1E00);
    chk("inset", gpio_out, 4'hC);
    ext <= 4'h9;
    repeat (3) @(posedge clock);
    acc(0, LEVEL_READ_ADDR, 16'h0000);
    chk("level", reg_rdata, 16'h1200);
  endtask
  task automatic t_ctrl;
    acc(1, SLEW_CTRL_ADDR, 16'h0070);
    chk("slew", pad_slew, 3'h7);
    acc(1, DIRECTION_ADDR, 16'h0000);
    acc(1, OE_PIN_CFG_ADDR, 16'h0100);
    chk("oe", gpio_oe, 4'h7);
    @(posedge clock);
    par_port_enable <= 1'b1;
    #1 chk("drv", par_port_drive, 1'b0);
    @(posedge clock);
    ext <= 4'h1;
    #1 chk("drv", par_port_drive, 1'b1);
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset;
    t_pins;
    t_ctrl;
    conclude;
  end
  initial begin
    #20000;
    miscompares++;
    conclude;
  end
endmodule
bind fgp_gpio_port fgp_props PROPS (.*);
